// ### hdl/skx_addr_resolve.sv
/*
  Data-memory address resolution for a file-register operand.
  Assumes the caller registers the result; this module is purely combinational.
*/
`timescale 1ns/1ps
module skx_addr_resolve (
  // Operand fields
  input wire logic [7:0] operand,
  input wire logic access,
  // Addressing context
  input wire logic ext_enable,
  input wire logic [3:0] bank,
  input wire logic [11:0] index_base,
  // Result
  output skx_pkg::skx_resolved_t resolved
);

  always_comb
  begin
    resolved.indexed = 1'b0;
    if (!access && ext_enable && operand <= skx_pkg::INDEX_LIMIT)
    begin
      // The offset wraps within the data space rather than faulting.
      resolved.indexed = 1'b1;
      resolved.addr = index_base + {4'h0, operand};
    end
    else if (!access)
    begin
      if (operand < skx_pkg::ACCESS_SPLIT)
        resolved.addr = {skx_pkg::ACCESS_LOW_BANK, operand};
      else
        resolved.addr = {skx_pkg::ACCESS_HIGH_BANK, operand};
    end
    else
    begin
      resolved.addr = {bank, operand};
    end
  end

endmodule

// ### hdl/skx_exec.sv
/*
  Execution unit for compare-skip-less, test-skip-zero and xor-literal, with an
  AXI4-Lite register file. Assumes the fetch pipeline offers one word at a time
  and says whether the following word begins a two-word instruction, and that the
  data memory returns read data in the cycle after its read enable.
*/
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module skx_exec (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Fetch pipeline
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_next_two_word,
  output logic fetch_ready,
  output logic discard_prefetch,
  output logic instr_done,
  // Data memory
  output logic mem_rd_en,
  output logic [11:0] mem_addr,
  input wire logic [7:0] mem_rdata
);

  typedef enum logic [2:0] {st_idle, st_q1, st_q2, st_q3, st_q4, st_skip} skx_state_t;

  skx_state_t state;
  logic [15:0] instr_word;
  logic two_word_next;
  skx_pkg::skx_decoded_t dec;
  skx_pkg::skx_decoded_t cur;
  skx_pkg::skx_resolved_t res;
  logic skip_q;
  logic [2:0] skip_left;
  logic [1:0] last_cycles;
  logic [7:0] skip_count;
  logic ext_enable;
  logic [3:0] bank;
  logic [7:0] accum;
  logic flag_neg;
  logic flag_zero;
  logic bad_op;
  logic [11:0] index_base;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [7:0] wr_word;
  logic [7:0] xor_result;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  function automatic skx_pkg::skx_decoded_t decode(input logic [15:0] word);
    skx_pkg::skx_decoded_t d;
    d.op = skx_pkg::op_nop;
    d.known = 1'b1;
    d.access = word[8];
    d.operand = word[7:0];
    if (word[15:9] == skx_pkg::OPC_CMP_LESS)
      d.op = skx_pkg::op_cmp_less;
    else if (word[15:9] == skx_pkg::OPC_TEST_ZERO)
      d.op = skx_pkg::op_test_zero;
    else if (word[15:8] == skx_pkg::OPC_XOR_LIT)
      d.op = skx_pkg::op_xor_lit;
    else
      d.known = 1'b0;
    return d;
  endfunction

  assign cur = decode(instr_word);
  assign xor_result = accum ^ dec.operand;

  skx_addr_resolve u_resolve (
    .operand(cur.operand),
    .access(cur.access),
    .ext_enable(ext_enable),
    .bank(bank),
    .index_base(index_base),
    .resolved(res)
  );

  // Instruction sequencing through the four phases of each cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= st_idle;
      instr_word <= 16'h0000;
      two_word_next <= 1'b0;
      dec <= '0;
      skip_q <= 1'b0;
      skip_left <= 3'h0;
      last_cycles <= 2'h0;
      skip_count <= 8'h00;
      fetch_ready <= 1'b0;
      discard_prefetch <= 1'b0;
      instr_done <= 1'b0;
      mem_rd_en <= 1'b0;
      mem_addr <= 12'h000;
    end
    else
    begin
      discard_prefetch <= 1'b0;
      instr_done <= 1'b0;
      case (state)
        st_idle:
        begin
          fetch_ready <= 1'b1;
          if (fetch_valid && fetch_ready)
          begin
            fetch_ready <= 1'b0;
            instr_word <= fetch_word;
            two_word_next <= fetch_next_two_word;
            state <= st_q1;
          end
        end
        st_q1:
        begin
          dec <= cur;
          mem_addr <= res.addr;
          mem_rd_en <= (cur.op == skx_pkg::op_cmp_less) || (cur.op == skx_pkg::op_test_zero);
          state <= st_q2;
        end
        st_q2:
        begin
          mem_rd_en <= 1'b0;
          state <= st_q3;
        end
        st_q3:
        begin
          // Unsigned compare: a borrow from file minus accumulator means smaller.
          skip_q <= ((dec.op == skx_pkg::op_cmp_less) && (mem_rdata < accum))
                    || ((dec.op == skx_pkg::op_test_zero) && (mem_rdata == 8'h00));
          state <= st_q4;
        end
        st_q4:
        begin
          if (skip_q)
          begin
            discard_prefetch <= 1'b1;
            skip_left <= two_word_next ? skx_pkg::SKIP_LAST_TWO : skx_pkg::SKIP_LAST_ONE;
            skip_count <= skip_count + 8'h01;
            state <= st_skip;
          end
          else
          begin
            last_cycles <= skx_pkg::CYCLES_PLAIN;
            instr_done <= 1'b1;
            fetch_ready <= 1'b1;
            state <= st_idle;
          end
        end
        st_skip:
        begin
          // Skip phases touch neither memory nor the accumulator.
          if (skip_left == 3'h0)
          begin
            last_cycles <= two_word_next ? skx_pkg::CYCLES_SKIP_TWO : skx_pkg::CYCLES_SKIP;
            instr_done <= 1'b1;
            fetch_ready <= 1'b1;
            state <= st_idle;
          end
          else
          begin
            skip_left <= skip_left - 3'h1;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Accumulator and flags; the executing instruction wins over a bus write.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accum <= skx_pkg::RST_ACCUM;
      flag_neg <= 1'b0;
      flag_zero <= 1'b0;
    end
    else if (state == st_q4 && dec.op == skx_pkg::op_xor_lit)
    begin
      accum <= xor_result;
      flag_neg <= xor_result[7];
      flag_zero <= (xor_result == 8'h00);
    end
    else if (do_write && wr_word == skx_pkg::OFF_ACCUM && w_strb_q[0])
    begin
      accum <= w_data_q[7:0];
    end
  end

  // Unknown opcodes run as a no-op and leave a sticky mark; a new mark beats a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bad_op <= 1'b0;
    else if (state == st_q1 && !cur.known)
      bad_op <= 1'b1;
    else if (do_write && wr_word == skx_pkg::OFF_STATUS && w_strb_q[0] && w_data_q[skx_pkg::STAT_BADOP_BIT])
      bad_op <= 1'b0;
  end

  // Addressing controls written by software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_enable <= skx_pkg::RST_EXT;
      bank <= skx_pkg::RST_BANK;
      index_base <= skx_pkg::RST_INDEX;
    end
    else if (do_write)
    begin
      if (wr_word == skx_pkg::OFF_CTRL && w_strb_q[0])
        ext_enable <= w_data_q[skx_pkg::CTRL_EXT_BIT];
      if (wr_word == skx_pkg::OFF_BANK && w_strb_q[0])
        bank <= w_data_q[3:0];
      if (wr_word == skx_pkg::OFF_INDEX && w_strb_q[0])
        index_base[7:0] <= w_data_q[7:0];
      if (wr_word == skx_pkg::OFF_INDEX && w_strb_q[1])
        index_base[11:8] <= w_data_q[11:8];
    end
  end

  // Write address and data are taken independently; the response waits for both.
  assign do_write = !awready && !wready && !bvalid;
  assign wr_word = {aw_addr_q[7:2], 2'b00};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= skx_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      else if (bvalid && bready)
      begin
        awready <= 1'b1;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (bvalid && bready)
      begin
        wready <= 1'b1;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= (wr_word <= skx_pkg::OFF_COUNT) ? skx_pkg::RESP_OKAY : skx_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = skx_pkg::RESP_OKAY;
    case ({araddr[7:2], 2'b00})
      skx_pkg::OFF_CTRL: next_rdata[skx_pkg::CTRL_EXT_BIT] = ext_enable;
      skx_pkg::OFF_BANK: next_rdata[3:0] = bank;
      skx_pkg::OFF_ACCUM: next_rdata[7:0] = accum;
      skx_pkg::OFF_STATUS:
      begin
        next_rdata[skx_pkg::STAT_ZERO_BIT] = flag_zero;
        next_rdata[skx_pkg::STAT_NEG_BIT] = flag_neg;
        next_rdata[skx_pkg::STAT_BUSY_BIT] = (state != st_idle);
        next_rdata[skx_pkg::STAT_BADOP_BIT] = bad_op;
      end
      skx_pkg::OFF_INDEX: next_rdata[11:0] = index_base;
      skx_pkg::OFF_COUNT:
      begin
        next_rdata[1:0] = last_cycles;
        next_rdata[skx_pkg::COUNT_SKIPS_LSB +: 8] = skip_count;
      end
      default: next_rresp = skx_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= skx_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cmp_skip_taken: assert property ((state == st_q3 && dec.op == skx_pkg::op_cmp_less && mem_rdata < accum)
    |=> state == st_q4 ##1 state == st_skip) else $error("compare smaller did not skip");
  a_cmp_no_skip: assert property ((state == st_q3 && dec.op == skx_pkg::op_cmp_less && mem_rdata >= accum)
    |=> ##1 (instr_done && state == st_idle)) else $error("compare not smaller skipped");
  a_operand_field: assert property ((state == st_q2)
    |-> (dec.operand == instr_word[7:0] && dec.access == instr_word[8])) else $error("operand field misdecoded");
  a_test_zero_skip: assert property ((state == st_q3 && dec.op == skx_pkg::op_test_zero)
    |=> ##1 ((state == st_skip) == ($past(mem_rdata, 2) == 8'h00))) else $error("test zero skip wrong");
  a_flags_hold: assert property ((state == st_q4 && dec.op != skx_pkg::op_xor_lit)
    |=> ($stable(flag_neg) && $stable(flag_zero))) else $error("flags changed by skip instruction");
  a_skip_one_word: assert property ((state == st_q4 && skip_q && !two_word_next)
    |=> discard_prefetch ##0 (state == st_skip)[*4] ##1 (state == st_idle && instr_done)) else $error("one-word skip length");
  a_skip_two_word: assert property ((state == st_q4 && skip_q && two_word_next)
    |=> (state == st_skip)[*8] ##1 (last_cycles == skx_pkg::CYCLES_SKIP_TWO)) else $error("two-word skip length");
  a_access_bank: assert property ((state == st_q1 && !instr_word[8] && !ext_enable)
    |=> (mem_addr[7:0] == instr_word[7:0] && mem_addr[11:8] == ((instr_word[7:0] < skx_pkg::ACCESS_SPLIT)
        ? skx_pkg::ACCESS_LOW_BANK : skx_pkg::ACCESS_HIGH_BANK))) else $error("access bank address wrong");
  a_bank_select: assert property ((state == st_q1 && instr_word[8])
    |=> mem_addr == {$past(bank), instr_word[7:0]}) else $error("banked address wrong");
  a_indexed_offset: assert property ((state == st_q1 && !instr_word[8] && ext_enable && instr_word[7:0] <= 8'h5F)
    |=> mem_addr == $past(index_base) + {4'h0, instr_word[7:0]}) else $error("indexed address wrong");
  a_xor_result: assert property ((state == st_q4 && dec.op == skx_pkg::op_xor_lit)
    |=> (accum == ($past(accum) ^ $past(dec.operand)) && flag_zero == (accum == 8'h00) && flag_neg == accum[7]))
    else $error("xor result or flags wrong");
  a_xor_single: assert property ((state == st_q1 && cur.op == skx_pkg::op_xor_lit)
    |=> !mem_rd_en ##3 (state == st_idle && instr_done && !discard_prefetch && last_cycles == skx_pkg::CYCLES_PLAIN))
    else $error("xor not single cycle");
  a_four_phase: assert property ((state == st_q1)
    |=> state == st_q2 ##1 state == st_q3 ##1 state == st_q4) else $error("phase order broken");
  a_skip_quiet: assert property ((state == st_skip)
    |-> (!mem_rd_en && ($stable(accum) || $past(do_write)))) else $error("activity during skip");

  c_cmp_skip: cover property (state == st_q4 && skip_q && dec.op == skx_pkg::op_cmp_less);
  c_zero_two_word: cover property (state == st_q4 && skip_q && two_word_next && dec.op == skx_pkg::op_test_zero);
  c_xor_done: cover property (state == st_q4 && dec.op == skx_pkg::op_xor_lit ##1 instr_done);
  c_indexed: cover property (state == st_q1 && res.indexed);

endmodule

// ### hdl/skx_pkg.sv
/*
  Shared constants and types for the skip, compare and xor execution block:
  register offsets, field positions, reset values, opcodes and carriers.
  Assumes an 8-bit data path, a 12-bit data-memory address and AXI4-Lite access.
*/
package skx_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int MEM_ADDR_W = 12;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BANK = 8'h04;
  localparam logic [7:0] OFF_ACCUM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INDEX = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;

  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_NEG_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_BADOP_BIT = 3;
  localparam int COUNT_SKIPS_LSB = 8;

  localparam logic RST_EXT = 1'h0;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic [11:0] RST_INDEX = 12'h000;

  localparam logic [6:0] OPC_CMP_LESS = 7'h30;
  localparam logic [6:0] OPC_TEST_ZERO = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0A;

  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  localparam logic [2:0] SKIP_LAST_ONE = 3'h3;
  localparam logic [2:0] SKIP_LAST_TWO = 3'h7;
  localparam logic [1:0] CYCLES_PLAIN = 2'h1;
  localparam logic [1:0] CYCLES_SKIP = 2'h2;
  localparam logic [1:0] CYCLES_SKIP_TWO = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {op_nop, op_cmp_less, op_test_zero, op_xor_lit} skx_op_t;

  typedef struct packed {
    skx_op_t op;
    logic known;
    logic access;
    logic [7:0] operand;
  } skx_decoded_t;

  typedef struct packed {
    logic [11:0] addr;
    logic indexed;
  } skx_resolved_t;

endpackage

// ### verification/skx_mem_model.sv
/*
  Data-memory model that answers the execution block's read port.
  Assumes one read at a time, with data expected in the cycle after the enable.
*/
`timescale 1ns/1ps
module skx_mem_model (
  // Clock
  input wire logic aclk,
  // Read port
  input wire logic mem_rd_en,
  input wire logic [11:0] mem_addr,
  output logic [7:0] mem_rdata,
  // Observation
  output logic [11:0] last_addr
);
  logic [7:0] mem [4096];

  initial mem_rdata = 8'hA5;
  initial last_addr = 12'h000;

  // Outside its one valid cycle the data toggles, so a late sample cannot match by luck.
  always @(posedge aclk)
  begin
    if (mem_rd_en)
    begin
      mem_rdata <= mem[mem_addr];
      last_addr <= mem_addr;
    end
    else
    begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ### verification/test_skip_compare_xor_exec.sv
/*
  Self-checking bench for the execution block: reset values and an unmapped register,
  then a table of instruction cases and an unknown opcode.
  Assumes the data-memory model answers one cycle after each read enable.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); \
    end \
  end
module test_skip_compare_xor_exec;
  typedef struct packed {
    logic [15:0] word;
    logic two;
    logic ext;
    logic [3:0] bank;
    logic [11:0] idx;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [11:0] addr;
    logic [3:0] cyc;
    logic [7:0] acc_out;
    logic [1:0] flags;
  } skx_row_t;

  // Flags are {negative, zero}; only the xor rows may change them.
  skx_row_t rows [12] = '{
    '{16'h0AAF, 1'b0, 1'b0, 4'h0, 12'h000, 8'hB5, 8'h00, 12'h000, 4'h4, 8'h1A, 2'h0},
    '{16'h0A00, 1'b1, 1'b0, 4'h0, 12'h000, 8'h80, 8'h00, 12'h000, 4'h4, 8'h80, 2'h2},
    '{16'h0A5A, 1'b0, 1'b0, 4'h0, 12'h000, 8'h5A, 8'h00, 12'h000, 4'h4, 8'h00, 2'h1},
    '{16'h6020, 1'b0, 1'b0, 4'h0, 12'h000, 8'h11, 8'h10, 12'h020, 4'h8, 8'h11, 2'h1},
    '{16'h6020, 1'b0, 1'b0, 4'h0, 12'h000, 8'h11, 8'h11, 12'h020, 4'h4, 8'h11, 2'h1},
    '{16'h6145, 1'b1, 1'b0, 4'h3, 12'h000, 8'h01, 8'h00, 12'h345, 4'hC, 8'h01, 2'h1},
    '{16'h6660, 1'b0, 1'b0, 4'h0, 12'h000, 8'h22, 8'h00, 12'hF60, 4'h8, 8'h22, 2'h1},
    '{16'h665F, 1'b0, 1'b1, 4'h0, 12'h123, 8'h22, 8'h01, 12'h182, 4'h4, 8'h22, 2'h1},
    '{16'h6660, 1'b0, 1'b1, 4'h0, 12'h123, 8'h22, 8'h80, 12'hF60, 4'h4, 8'h22, 2'h1},
    '{16'h67FF, 1'b1, 1'b0, 4'hF, 12'h000, 8'h22, 8'h00, 12'hFFF, 4'hC, 8'h22, 2'h1},
    '{16'h6010, 1'b0, 1'b1, 4'h0, 12'hFF8, 8'h80, 8'h7F, 12'h008, 4'h8, 8'h80, 2'h1},
    '{16'h605F, 1'b0, 1'b0, 4'h0, 12'h000, 8'h40, 8'h41, 12'h05F, 4'h4, 8'h40, 2'h1}
  };

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic fetch_valid = 1'b0, fetch_next_two_word = 1'b0;
  logic [15:0] fetch_word = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, fetch_ready, discard_prefetch, instr_done, mem_rd_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] mem_addr, last_addr;
  logic [7:0] mem_rdata;
  int err_total = 0, check_count = 0;

  always #5 aclk = ~aclk;

  skx_exec u_skx_exec (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF),
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .fetch_valid, .fetch_word, .fetch_next_two_word, .fetch_ready, .discard_prefetch, .instr_done,
    .mem_rd_en, .mem_addr, .mem_rdata
  );

  skx_mem_model u_skx_mem_model (.aclk, .mem_rd_en, .mem_addr, .mem_rdata, .last_addr);

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The slave may take address and data at different edges.
    do
    begin
      @(posedge aclk);
      if (awvalid && awready && !ad)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready && !dd)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!(ad && dd));
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (!arready);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!rvalid);
    d = {rdata[31:2], rdata[1:0] | {2{rresp[1]}}};
    rready <= 1'b0;
  endtask

  task automatic run(input logic [15:0] w, input logic two, output int n, output int rd, output int dc);
    n = 0;
    rd = 0;
    dc = 0;
    @(posedge aclk);
    fetch_word <= w;
    fetch_next_two_word <= two;
    fetch_valid <= 1'b1;
    do
      @(posedge aclk);
    while (!fetch_ready);
    fetch_valid <= 1'b0;
    // Cycles are counted from the taking edge; the bound stops a missing completion.
    do
    begin
      @(posedge aclk);
      #1;
      n++;
      rd += int'(mem_rd_en !== 1'b0);
      dc += int'(discard_prefetch !== 1'b0);
    end
    while (!instr_done && n < 16);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    logic [31:0] v;
    int n, rd, dc;
    logic [7:0] skips;
    skx_row_t r;
    skips = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4)
    begin
      axr(8'(a), v);
      `CHK(v, 32'h0000_0000)
    end
    // Unmapped reads come back as zero with an error flagged in the low bits.
    axw(8'h18, 32'h0000_0001, skx_pkg::RESP_SLVERR);
    axr(8'h18, v);
    `CHK(v, 32'h0000_0003)
    foreach (rows[i])
    begin
      r = rows[i];
      axw(skx_pkg::OFF_CTRL, {31'h0, r.ext}, skx_pkg::RESP_OKAY);
      axw(skx_pkg::OFF_BANK, {28'h000_0000, r.bank}, skx_pkg::RESP_OKAY);
      axw(skx_pkg::OFF_INDEX, {20'h0_0000, r.idx}, skx_pkg::RESP_OKAY);
      axw(skx_pkg::OFF_ACCUM, {24'h00_0000, r.acc}, skx_pkg::RESP_OKAY);
      u_skx_mem_model.mem[r.addr] = r.mem;
      run(r.word, r.two, n, rd, dc);
      `CHK(n, int'(r.cyc))
      `CHK(dc, int'(r.cyc > 4'h4))
      `CHK(rd, int'(r.word[15:12] == 4'h6))
      if (r.word[15:12] == 4'h6) `CHK(last_addr, r.addr)
      axr(skx_pkg::OFF_ACCUM, v);
      `CHK(v[7:0], r.acc_out)
      axr(skx_pkg::OFF_STATUS, v);
      `CHK(v[3:0], {2'b00, r.flags})
      if (r.cyc > 4'h4)
        skips++;
      axr(skx_pkg::OFF_COUNT, v);
      `CHK(v[15:0], {skips, 6'h00, r.cyc[3:2]})
    end
    run(16'hFFFF, 1'b0, n, rd, dc);
    `CHK(instr_done, 1'b1)
    axr(skx_pkg::OFF_STATUS, v);
    `CHK(v[3:0], 4'h9)
    axw(skx_pkg::OFF_STATUS, 32'h0000_0008, skx_pkg::RESP_OKAY);
    axr(skx_pkg::OFF_STATUS, v);
    `CHK(v[3:0], 4'h1)
    // A reset in the middle of an instruction abandons it and restores every register.
    axw(skx_pkg::OFF_BANK, 32'h0000_0005, skx_pkg::RESP_OKAY);
    fetch_word <= 16'h6660;
    fetch_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    fetch_valid <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4)
    begin
      axr(8'(a), v);
      `CHK(v, 32'h0000_0000)
    end
    run(16'h0A81, 1'b0, n, rd, dc);
    `CHK(n, 4)
    axr(skx_pkg::OFF_STATUS, v);
    `CHK(v[3:0], 4'h2)
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end
endmodule
